//--- logic/mbi_host.sv
// mbi_host: host end, runs one read or write cycle per request
// assumes: device end joined by mbi_if, same clock
`timescale 1ns/1ps
`default_nettype none
module mbi_host #(
    parameter mbi_pkg::mbi_style_type STYLE = mbi_pkg::MBI_STYLE_SEP_RD
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // host pins
    mbi_if.host              BUS,
    // request
    input  wire logic        REQ,
    input  wire logic        REQ_WRITE,
    input  wire logic        REQ_FETCH,
    input  wire logic [16:0] REQ_ADDR,
    input  wire logic [7:0]  REQ_DATA,
    // answer
    output var logic         BUSY,
    output var logic         DONE,
    output var logic [7:0]   RD_DATA
);
    typedef enum logic [4:0] {
        H_IDLE = 5'h01, H_ADDR = 5'h02, H_HOLD = 5'h04, H_STRB = 5'h08, H_END = 5'h10
    } mbi_hst_type;
    typedef struct packed {
        mbi_hst_type st;
        logic [2:0]  cnt;
        logic        wr, fe, done, busy;
        logic [16:0] addr;
        logic [7:0]  wdat, rdat;
        logic        c0, c1, c2, as;
        logic [7:0]  ad_o;
        logic        ad_oe, pa_oe;
        logic [7:0]  pa_o;
    } mbi_h_type;
    mbi_h_type s_reg, s_next;
    logic nonmux;
    assign nonmux = (STYLE == mbi_pkg::MBI_STYLE_NONMUX);

    // sequence: address phase, address hold while the device sync catches up (muxed styles only), strobe, hold
    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        unique case (s_reg.st)
            H_IDLE: if (REQ) begin
                s_next.wr   = REQ_WRITE;
                s_next.fe   = REQ_FETCH;
                s_next.addr = REQ_ADDR;
                s_next.wdat = REQ_DATA;
                s_next.st   = H_ADDR;
                s_next.ad_o = REQ_ADDR[7:0];
                s_next.ad_oe = 1'b1;
                s_next.pa_o = {7'h00, REQ_ADDR[16]}; // RL14
                s_next.pa_oe = ~nonmux;
                s_next.as   = ~nonmux; // RL3
                s_next.cnt  = mbi_pkg::MBI_T_AS;
            end
            H_ADDR: begin
                s_next.cnt = s_reg.cnt - 3'h1;
                if (s_reg.cnt == 3'h0 && s_reg.as) begin
                    // device sees the strobe fall late, so the address stays a while
                    s_next.as  = 1'b0;
                    s_next.cnt = mbi_pkg::MBI_T_AS_HOLD; // RL19
                end else if (s_reg.cnt == 3'h0) begin
                    s_next.st  = H_STRB;
                    s_next.cnt = mbi_pkg::MBI_T_STRB;
                    if (!nonmux) begin
                        s_next.ad_o  = s_reg.wdat;
                        s_next.ad_oe = s_reg.wr;
                    end else begin
                        s_next.pa_o  = s_reg.wdat; // RL10
                        s_next.pa_oe = s_reg.wr;
                    end
                    if (STYLE == mbi_pkg::MBI_STYLE_RW_EN) begin
                        s_next.c0 = ~s_reg.wr;
                        s_next.c1 = 1'b1;
                    end else if (s_reg.wr) begin
                        s_next.c0 = 1'b0;
                    end else if (s_reg.fe && STYLE != mbi_pkg::MBI_STYLE_FETCH) begin
                        s_next.c2 = 1'b0; // RL13
                    end else begin
                        s_next.c1 = 1'b0; // RL12
                    end
                end
            end
            H_STRB: begin
                s_next.cnt = s_reg.cnt - 3'h1;
                if (s_reg.cnt == 3'h0) begin
                    s_next.rdat = nonmux ? BUS.port_a : BUS.addr_data_port;
                    s_next.c0 = (STYLE != mbi_pkg::MBI_STYLE_RW_EN);
                    s_next.c1 = (STYLE != mbi_pkg::MBI_STYLE_RW_EN);
                    s_next.c2 = 1'b1;
                    s_next.st = H_HOLD;
                    s_next.cnt = mbi_pkg::MBI_T_END;
                end
            end
            H_HOLD: begin
                s_next.cnt = s_reg.cnt - 3'h1;
                if (s_reg.cnt == 3'h0) begin
                    s_next.ad_oe = 1'b0;
                    s_next.pa_oe = 1'b0;
                    s_next.st    = H_END;
                end
            end
            H_END: begin
                s_next.done = 1'b1;
                s_next.st   = H_IDLE;
            end
            default: s_next.st = H_IDLE;
        endcase
        s_next.busy = (s_next.st != H_IDLE);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_reg    <= '0;
            s_reg.st <= H_IDLE;
            s_reg.c0 <= 1'b1;
            s_reg.c1 <= (STYLE != mbi_pkg::MBI_STYLE_RW_EN);
            s_reg.c2 <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        BUS.ctrl_input_first     = s_reg.c0;
        BUS.ctrl_input_second    = s_reg.c1;
        BUS.ctrl_input_third     = s_reg.c2;
        BUS.address_strobe_input = s_reg.as;
        BUS.addr_data_port_o     = s_reg.ad_o;
        BUS.addr_data_port_oe_h  = s_reg.ad_oe;
        BUS.port_a_o_h           = s_reg.pa_o;
        BUS.port_a_oe_h          = s_reg.pa_oe;
        BUS.addr_hi_port         = s_reg.addr[15:8];
    end
    assign BUSY    = s_reg.busy;
    assign DONE    = s_reg.done;
    assign RD_DATA = s_reg.rdat;
endmodule
`default_nettype wire

//--- include/mbi_pkg.sv
// mbi_pkg: constants and types shared by both ends of the host bus port
// assumes: one 20 MHz clock, both ends joined by mbi_if in the testbench
// Notes on behaviour
// [RL1] bus style chosen once, roles per control input
// [RL2] spare third control input passes to logic
// [RL3] address strobe optional on non-multiplexed hosts
// [RL4] multiplexed address captured by address strobe
// [RL5] latched address may drive port A or B; here only port B, when LAT_TO_B is set
// [RL6] drive data port only on selected read
// [RL7] ports give extra address bits beyond sixteen
// [RL8] non-muxed: address on data port, data port A
// [RL9] non-muxed: port A undriven when not accessed
// [RL10] port A nibbles carry D3-D0 and D7-D4
// [RL11] address bit zero picks even or odd byte
// [RL12] single read: fetch strobe on second input
// [RL13] read on second, fetch on third input
// [RL14] address bit sixteen on port A bit zero
// [RL15] write, read, fetch all reach memory and ports
// [RL16] 4-bit low address on port A nibble
// [RL17] page hit decodes without new latch event
// [RL18] burst keeps upper address, low four change
// [RL19] latch follows strobe, holds after its fall
package mbi_pkg;
    // bus styles, fixed at configuration time
    typedef enum logic [2:0] {
        MBI_STYLE_SEP_RD   = 3'h0, // write, read, fetch strobes
        MBI_STYLE_FETCH    = 3'h1, // write plus fetch as only read
        MBI_STYLE_RW_EN    = 3'h2, // read/write line plus enable
        MBI_STYLE_BURST    = 3'h3, // low four address bits not muxed
        MBI_STYLE_NONMUX   = 3'h4  // address on data port, data on port a
    } mbi_style_type;

    localparam int MBI_DATA_W   = 8;
    localparam int MBI_ADDR_W   = 17;  // sixteen bus bits plus bit sixteen
    localparam int MBI_NIB_W    = 4;
    localparam int MBI_MEM_W    = 10;  // address bits of the device model memory, 1024 bytes
    localparam int MBI_SYNC_LEN = 3;
    // host cycle counts; the device sees a pin change four edges late
    localparam logic [2:0] MBI_T_AS      = 3'h5;  // address strobe high six cycles
    localparam logic [2:0] MBI_T_AS_HOLD = 3'h4;  // address kept five cycles after strobe falls
    localparam logic [2:0] MBI_T_STRB    = 3'h7;  // read or write strobe low eight cycles
    localparam logic [2:0] MBI_T_END     = 3'h6;  // data kept seven cycles after strobe rises
    localparam logic [7:0] MBI_DATA_RST = 8'h00;
endpackage

//--- include/mbi_if.sv
// mbi_if: pins between the host end and the device end
// assumes: testbench resolves the shared wires from the enables
`timescale 1ns/1ps
`default_nettype none
interface mbi_if;
    logic       ctrl_input_first;
    logic       ctrl_input_second;
    logic       ctrl_input_third;
    logic       address_strobe_input;
    logic [7:0] addr_data_port_o;   // host drive
    logic       addr_data_port_oe_h;
    logic [7:0] addr_data_port_d;   // device drive
    logic       addr_data_port_oe_d;
    logic [7:0] port_a_o_h;
    logic       port_a_oe_h;
    logic [7:0] port_a_o_d;
    logic       port_a_oe_d;
    logic [7:0] port_b_o_d;
    logic       port_b_oe_d;
    logic [7:0] addr_hi_port;       // host drives extra address on port b/c/d
    logic [7:0] addr_data_port;     // resolved wire
    logic [7:0] port_a;             // resolved wire
    modport host (output ctrl_input_first, ctrl_input_second, ctrl_input_third,
                  address_strobe_input, addr_data_port_o, addr_data_port_oe_h,
                  port_a_o_h, port_a_oe_h, addr_hi_port,
                  input addr_data_port, port_a);
    modport device (input ctrl_input_first, ctrl_input_second, ctrl_input_third,
                    address_strobe_input, addr_hi_port, addr_data_port, port_a,
                    output addr_data_port_d, addr_data_port_oe_d, port_a_o_d,
                    port_a_oe_d, port_b_o_d, port_b_oe_d);
endinterface
`default_nettype wire

//--- logic/mbi_device.sv
// mbi_device: device end, decodes host strobes and serves a small memory
// assumes: host pins arrive asynchronously; style fixed while running
`timescale 1ns/1ps
`default_nettype none
module mbi_device #(
    parameter mbi_pkg::mbi_style_type STYLE   = mbi_pkg::MBI_STYLE_SEP_RD,
    parameter logic                   LAT_TO_B = 1'b1, // latched address to port b
    parameter int                     MEM_W   = mbi_pkg::MBI_MEM_W
) (
    // clock and reset
    input  wire logic CLK,
    input  wire logic RST,
    // host pins
    mbi_if.device     BUS,
    // user side
    output var logic       SPARE_INPUT,
    output var logic [16:0] LAST_ADDR,
    output var logic       LAST_ODD,
    output var logic       WRITE_SEEN
);
    typedef struct packed {
        logic [2:0][3:0] sync;       // ctrl0..2 and strobe, three stages
        logic [3:0]      filt;       // levels once stages two and three agree
        logic [16:0]     addr_lat;
        logic [16:0]     last_addr;
        logic            last_odd;
        logic            wr_seen;
        logic            rd_act;
        logic            spare;
        logic [7:0]      rd_data;
        logic            wr_prev;
    } mbi_dev_type;
    mbi_dev_type s_reg, s_next;
    logic [7:0] mem [0:(1<<MEM_W)-1];
    logic [3:0] pins;
    logic       c0, c1, c2, as_now, wr_now, rd_now;
    logic [16:0] cur_addr;
    logic [7:0]  wr_data;
    logic       wr_edge;
    // pin levels of an idle host, so no false strobe edge follows reset
    localparam logic [3:0] IDLE_PINS = {1'b0, 1'b1, STYLE != mbi_pkg::MBI_STYLE_RW_EN, 1'b1};

    assign pins = {BUS.address_strobe_input, BUS.ctrl_input_third,
                   BUS.ctrl_input_second, BUS.ctrl_input_first};

    // decode roles of control inputs from settled pin levels
    always_comb begin
        c0     = s_reg.filt[0];
        c1     = s_reg.filt[1];
        c2     = s_reg.filt[2];
        as_now = s_reg.filt[3];
        wr_now = 1'b0;
        rd_now = 1'b0;
        unique case (STYLE) // RL1
            mbi_pkg::MBI_STYLE_SEP_RD, mbi_pkg::MBI_STYLE_BURST,
            mbi_pkg::MBI_STYLE_NONMUX: begin
                wr_now = ~c0;
                rd_now = ~c1 | ~c2; // RL13 RL15
            end
            mbi_pkg::MBI_STYLE_FETCH: begin
                wr_now = ~c0;
                rd_now = ~c1; // RL12
            end
            mbi_pkg::MBI_STYLE_RW_EN: begin
                wr_now = ~c0 & c1;
                rd_now = c0 & c1;
            end
            default: begin
                wr_now = 1'b0;
                rd_now = 1'b0;
            end
        endcase
    end

    // address seen by the decoder for this cycle
    always_comb begin
        cur_addr = s_reg.addr_lat;
        wr_data  = BUS.addr_data_port;
        unique case (STYLE)
            mbi_pkg::MBI_STYLE_NONMUX: begin
                cur_addr = {BUS.addr_hi_port[0], BUS.addr_hi_port, BUS.addr_data_port}; // RL8
                wr_data  = {BUS.port_a[7:4], BUS.port_a[3:0]}; // RL10
            end
            mbi_pkg::MBI_STYLE_BURST:
                cur_addr = {s_reg.addr_lat[16:4], BUS.port_a[3:0]}; // RL16 RL18
            default:
                cur_addr = s_reg.addr_lat; // RL17 page hit keeps latch
        endcase
    end

    assign wr_edge = s_reg.wr_prev & ~wr_now; // write taken on trailing edge

    // single next-state process
    always_comb begin
        s_next          = s_reg;
        s_next.sync[0]  = pins;
        s_next.sync[1]  = s_reg.sync[0];
        s_next.sync[2]  = s_reg.sync[1];
        // a change counts only once stages two and three agree
        s_next.filt     = (s_reg.sync[1] & s_reg.sync[2]) |
                          (s_reg.filt & (s_reg.sync[1] | s_reg.sync[2]));
        s_next.wr_prev  = wr_now;
        // transparent while strobe high, holds after it falls; tied low means no event
        if (as_now && STYLE != mbi_pkg::MBI_STYLE_NONMUX) begin // RL19 RL4 RL3
            s_next.addr_lat = {BUS.port_a[0], BUS.addr_hi_port, BUS.addr_data_port}; // RL7 RL14
        end
        s_next.spare  = (STYLE == mbi_pkg::MBI_STYLE_FETCH) ? c2 : 1'b0; // RL2
        s_next.rd_act = rd_now;
        if (rd_now) begin
            s_next.rd_data = mem[cur_addr[MEM_W-1:0]];
        end
        if (wr_edge) begin
            s_next.last_addr = cur_addr;
            s_next.last_odd  = cur_addr[0]; // RL11
            s_next.wr_seen   = 1'b1;
        end
    end

    // memory write on trailing write edge
    always_ff @(posedge CLK) begin
        if (wr_edge) begin
            mem[cur_addr[MEM_W-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_reg      <= '0;
            s_reg.sync <= {3{IDLE_PINS}};
            s_reg.filt <= IDLE_PINS;
        end else begin
            s_reg <= s_next;
        end
    end

    // pin drives; read data only while selected read is active
    always_comb begin
        BUS.addr_data_port_d   = s_reg.rd_data;
        BUS.addr_data_port_oe_d = s_reg.rd_act && STYLE != mbi_pkg::MBI_STYLE_NONMUX; // RL6
        BUS.port_a_o_d         = s_reg.rd_data;
        BUS.port_a_oe_d        = s_reg.rd_act && STYLE == mbi_pkg::MBI_STYLE_NONMUX; // RL9
        BUS.port_b_o_d         = s_reg.addr_lat[7:0];
        BUS.port_b_oe_d        = LAT_TO_B && STYLE != mbi_pkg::MBI_STYLE_NONMUX; // RL5
    end

    assign SPARE_INPUT = s_reg.spare;
    assign LAST_ADDR   = s_reg.last_addr;
    assign LAST_ODD    = s_reg.last_odd;
    assign WRITE_SEEN  = s_reg.wr_seen;
endmodule
`default_nettype wire

//--- verif/mbi_chk_sva.sv
// mbi_chk: timing checks on the pins joining host end and device end
// assumes: muxed separate-strobe style, latched address on port b
`timescale 1ns/1ps
`default_nettype none
module mbi_chk (
    // clock and reset
    input wire logic       CLK,
    input wire logic       RST,
    // strobes, active low, and address strobe
    input wire logic       ctrl_input_first,
    input wire logic       ctrl_input_second,
    input wire logic       ctrl_input_third,
    input wire logic       address_strobe_input,
    // drivers
    input wire logic       addr_data_port_oe_h,
    input wire logic       addr_data_port_oe_d,
    input wire logic [7:0] port_b_o_d,
    input wire logic       port_b_oe_d
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // device pin drive follows the read strobes only
    chk_no_contend: assert property (!(addr_data_port_oe_h && addr_data_port_oe_d))
        else $error("data port driven by both ends");
    chk_drive_on_read: assert property ($rose(addr_data_port_oe_d)
        |-> !ctrl_input_second || !ctrl_input_third)
        else $error("device drove data port without read strobe");
    chk_read_release: assert property ($rose(ctrl_input_second)
        |-> ##[1:5] !addr_data_port_oe_d)
        else $error("data port not released after read");
    chk_fetch_release: assert property ($rose(ctrl_input_third)
        |-> ##[1:5] !addr_data_port_oe_d)
        else $error("data port not released after fetch");
    chk_no_wr_drive: assert property (!ctrl_input_first |-> !addr_data_port_oe_d)
        else $error("device drove data port during write");
    // one role per control input, one strobe at a time
    chk_strobe_one: assert property ($onehot0(~{ctrl_input_first, ctrl_input_second,
        ctrl_input_third}))
        else $error("two strobes active together");
    chk_as_width: assert property ($rose(address_strobe_input)
        |-> address_strobe_input[*6] ##1 !address_strobe_input)
        else $error("address strobe width wrong");
    chk_no_strobe_as: assert property (address_strobe_input
        |-> ctrl_input_first && ctrl_input_second && ctrl_input_third)
        else $error("strobe active while address latching");
    chk_strobe_width: assert property ($fell(ctrl_input_first)
        |-> (!ctrl_input_first)[*8] ##1 ctrl_input_first)
        else $error("write strobe width wrong");
    // latch holds once address strobe is gone long enough
    chk_latch_hold: assert property ((!address_strobe_input)[*8] |-> $stable(port_b_o_d))
        else $error("latched address moved without strobe");
    chk_latch_out: assert property (port_b_oe_d)
        else $error("latched address not driven on port b");
endmodule
`default_nettype wire

//--- verif/mcu_bus_interface_tb.sv
// mcu_bus_interface_tb: host end against device end, compared with a byte model
// assumes: a muxed and a non-muxed pair share requests; writes precede reads
`timescale 1ns/1ps
`default_nettype none
module mcu_bus_interface_tb;
    logic        CLK       = 1'b0;
    logic        RST       = 1'b1;
    logic        req       = 1'b0;
    logic        req_write = 1'b0;
    logic        req_fetch = 1'b0;
    logic [16:0] req_addr  = 17'h00000;
    logic [7:0]  req_data  = 8'h00;
    logic        busy, done, spare, last_odd, write_seen;
    logic [7:0]  rd_data;
    logic [16:0] last_addr;
    logic        busy_n, done_n, spare_n, last_odd_n, write_seen_n;
    logic [7:0]  rd_data_n;
    logic [16:0] last_addr_n;
    logic [7:0]  flt       = 8'h5a;
    logic [16:0] a;
    logic [7:0]  d;
    int          err_total   = 0;
    int          checks_done = 0;
    int          seed        = 79985;
    int          ops         = 0;
    int          done_n_cnt  = 0;
    logic [7:0]  mem_model [int];
    mbi_if bus ();
    mbi_if bus_n ();

    // an undriven wire toggles so a stale value never passes a compare
    always #25 CLK = ~CLK;
    always @(posedge CLK) flt <= ~flt;
    assign bus.addr_data_port = bus.addr_data_port_oe_h ? bus.addr_data_port_o :
                                bus.addr_data_port_oe_d ? bus.addr_data_port_d : flt;
    assign bus.port_a = bus.port_a_oe_h ? bus.port_a_o_h :
                        bus.port_a_oe_d ? bus.port_a_o_d : flt;
    assign bus_n.addr_data_port = bus_n.addr_data_port_oe_h ? bus_n.addr_data_port_o :
                                  bus_n.addr_data_port_oe_d ? bus_n.addr_data_port_d : flt;
    assign bus_n.port_a = bus_n.port_a_oe_h ? bus_n.port_a_o_h :
                          bus_n.port_a_oe_d ? bus_n.port_a_o_d : flt;

    mbi_host i_mbi_host (.CLK(CLK), .RST(RST), .BUS(bus), .REQ(req), .REQ_WRITE(req_write),
        .REQ_FETCH(req_fetch), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .BUSY(busy),
        .DONE(done), .RD_DATA(rd_data));
    mbi_device i_mbi_device (.CLK(CLK), .RST(RST), .BUS(bus), .SPARE_INPUT(spare),
        .LAST_ADDR(last_addr), .LAST_ODD(last_odd), .WRITE_SEEN(write_seen));
    mbi_chk i_mbi_chk (.CLK(CLK), .RST(RST), .ctrl_input_first(bus.ctrl_input_first),
        .ctrl_input_second(bus.ctrl_input_second), .ctrl_input_third(bus.ctrl_input_third),
        .address_strobe_input(bus.address_strobe_input),
        .addr_data_port_oe_h(bus.addr_data_port_oe_h),
        .addr_data_port_oe_d(bus.addr_data_port_oe_d),
        .port_b_o_d(bus.port_b_o_d), .port_b_oe_d(bus.port_b_oe_d));
    // the same requests drive a non-multiplexed pair, which always finishes first
    mbi_host #(.STYLE(mbi_pkg::MBI_STYLE_NONMUX)) i_mbi_host_nonmux (.CLK(CLK), .RST(RST),
        .BUS(bus_n), .REQ(req), .REQ_WRITE(req_write), .REQ_FETCH(req_fetch),
        .REQ_ADDR(req_addr), .REQ_DATA(req_data), .BUSY(busy_n), .DONE(done_n),
        .RD_DATA(rd_data_n));
    mbi_device #(.STYLE(mbi_pkg::MBI_STYLE_NONMUX)) i_mbi_device_nonmux (.CLK(CLK), .RST(RST),
        .BUS(bus_n), .SPARE_INPUT(spare_n), .LAST_ADDR(last_addr_n), .LAST_ODD(last_odd_n),
        .WRITE_SEEN(write_seen_n));
    // its done pulse is gone before the muxed one, so count pulses
    always @(negedge CLK) if (done_n === 1'b1) done_n_cnt++;

    // verdict and end of run
    task conclude;
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task compare(input logic [16:0] got, input logic [16:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one host cycle; bounded wait on the done pulse
    task run_op(input logic w, input logic f, input logic [16:0] ad, input logic [7:0] dt);
        int n;
        n = 0;
        @(negedge CLK);
        req = 1'b1;
        req_write = w;
        req_fetch = f;
        req_addr = ad;
        req_data = dt;
        @(negedge CLK);
        req = 1'b0;
        ops++;
        compare(17'(busy), 17'h00001);
        while (done !== 1'b1 && n < 60) begin
            @(posedge CLK);
            #1;
            n++;
        end
        compare(17'(done), 17'h00001);
        compare(17'(busy), 17'h00000);
    endtask

    initial begin
        #500us;
        err_total++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge CLK);
        @(negedge CLK);
        RST = 1'b0;
        compare(17'(spare), 17'h00000);
        compare(17'(write_seen), 17'h00000);
        // back-to-back writes in the low block, both byte parities
        for (int i = 0; i < 14; i++) begin
            a = 17'($random(seed)) & 17'h001ff;
            d = 8'($random(seed));
            mem_model[int'(a)] = d;
            run_op(1'b1, 1'b0, a, d);
            compare(last_addr, a);
            compare(17'(last_odd), 17'(a[0]));
            compare(17'(write_seen), 17'h00001);
            compare(17'(bus.port_b_o_d), 17'(a[7:0]));
            compare(17'(last_addr_n[15:0]), 17'(a[15:0]));
            compare(17'(last_odd_n), 17'(a[0]));
        end
        // writes with bit sixteen set, kept apart from the low block
        for (int i = 0; i < 4; i++) begin
            a = (17'($random(seed)) & 17'h1fcff) | 17'h10300;
            run_op(1'b1, 1'b0, a, 8'($random(seed)));
            compare(last_addr, a);
            compare(17'(last_addr_n[15:0]), 17'(a[15:0]));
            compare(17'(last_odd), 17'(a[0]));
        end
        // read back, even addresses through the read strobe, odd ones through fetch
        foreach (mem_model[k]) begin
            run_op(1'b0, 1'(k % 2), 17'(k), 8'h00);
            compare(17'(rd_data), 17'(mem_model[k]));
            compare(17'(rd_data_n), 17'(mem_model[k]));
            compare(17'(bus_n.port_a_oe_d), 17'h00000);
        end
        compare(17'(spare), 17'h00000);
        compare(17'(spare_n), 17'h00000);
        compare(17'(write_seen_n), 17'h00001);
        compare(17'(busy_n), 17'h00000);
        compare(17'(done_n_cnt), 17'(ops));
        conclude();
    end
endmodule
`default_nettype wire
